//--- design/arfcs_input_select.sv
/*
 * Shadow and lock of the positive and negative input selections.
 * Assumes written selections arrive from the register file on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module arfcs_input_select (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic lock_in,
  input wire logic [arfcs_pkg::SEL_W-1:0] pos_written_in,
  input wire logic [arfcs_pkg::SEL_W-1:0] neg_written_in,
  output logic [arfcs_pkg::SEL_W-1:0] pos_active_out,
  output logic [arfcs_pkg::SEL_W-1:0] neg_active_out
);
  import arfcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Active selection tracks the shadow unless a conversion holds it
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pos_active_out <= SEL_RESET;
      neg_active_out <= SEL_RESET;
    end else if (!lock_in) begin
      pos_active_out <= pos_written_in;
      neg_active_out <= neg_written_in;
    end  // Held while locked
  end

endmodule : arfcs_input_select

`default_nettype wire

//--- design/arfcs_pkg.sv
/*
 * Package for the converter result formatter and channel selector:
 * register offsets, field positions, reset values, states and timing.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package arfcs_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACCUM = 8'h04;
  localparam logic [7:0] ADDR_PRESC = 8'h08;
  localparam logic [7:0] ADDR_INIT_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_SAMPLE_LENGTH = 8'h10;
  localparam logic [7:0] ADDR_POS_SELECT = 8'h14;
  localparam logic [7:0] ADDR_NEG_SELECT = 8'h18;
  localparam logic [7:0] ADDR_COMMAND = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_RESULT = 8'h24;
  localparam logic [7:0] ADDR_ACTIVE_SELECT = 8'h28;

  // Control, command, status and active select bit positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LEFT_ADJUST_BIT = 1;
  localparam int CTRL_DIFF_BIT = 2;
  localparam int CMD_START_BIT = 0;
  localparam int STATUS_READY_BIT = 0;
  localparam int ACTIVE_NEG_LSB = 8;

  // Field widths
  localparam int SEL_W = 7;
  localparam int CONV_W = 12;
  localparam int SUM_W = 19;
  localparam int RES_W = 16;
  localparam int CNT_W = 8;

  // Reset values
  localparam logic [3:0] PRESC_RESET = 4'h1;
  localparam logic [CNT_W-1:0] INIT_DELAY_RESET = 8'h00;
  localparam logic [CNT_W-1:0] SAMPLE_LENGTH_RESET = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;

  // Positive selection code of the on-chip temperature sensor (free choice)
  localparam logic [SEL_W-1:0] SEL_TEMP_SENSOR = 7'h42;

  // Accumulation code whose sum fills the result exactly (16 samples)
  localparam logic [2:0] ACC_FULL_CODE = 3'h4;

  // Converter clock cycles spent converting after the sample phase
  localparam logic [CNT_W-1:0] CONV_TICKS = 8'h0D;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INIT = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONVERT = 2'b11
  } arfcs_state_e;

endpackage : arfcs_pkg

//--- design/arfcs_result_format.sv
/*
 * Packs an accumulated conversion sum into the 16-bit result word.
 * Assumes the sum is already sign or zero extended to the sum width.
 */
`timescale 1ns/1ps
`default_nettype none

module arfcs_result_format (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [arfcs_pkg::SUM_W-1:0] sum_in,
  input wire logic [2:0] count_in,
  input wire logic left_in,
  input wire logic diff_in,
  output logic [arfcs_pkg::RES_W-1:0] result_out
);
  import arfcs_pkg::*;

  logic [SUM_W-1:0] packed_next;

  //////////////////////////////////////////////////////////////////////////////
  // Up to 16 samples: right keeps the extension, left shifts to the top
  // Beyond 16 samples: drop low bits to fit, same for both adjustments
  always_comb begin
    packed_next = sum_in;
    if (count_in <= ACC_FULL_CODE) begin
      if (left_in) begin
        packed_next = sum_in << (ACC_FULL_CODE - count_in);
      end
    end else if (diff_in) begin
      packed_next = SUM_W'($signed(sum_in) >>> (count_in - ACC_FULL_CODE));
    end else begin
      packed_next = sum_in >> (count_in - ACC_FULL_CODE);
    end
  end

  // Result word register
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      result_out <= 16'h0000;
    end else if (load_in) begin
      result_out <= packed_next[RES_W-1:0];
    end
  end

endmodule : arfcs_result_format

`default_nettype wire

//--- design/arfcs_top.sv
/*
 * Converter control: Wishbone register file, converter clock divider,
 * conversion sequencer with accumulation, channel lock and result packing.
 * Assumes the converter core runs from ref_clk_in and presents its 12-bit
 * code on adc_data_in at the last tick of the convert phase.
 */
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module arfcs_top (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [arfcs_pkg::CONV_W-1:0] adc_data_in,
  output logic adc_clk_en_out,
  output logic adc_sample_out,
  output logic adc_convert_out,
  output logic diff_mode_out,
  output logic temp_sensor_en_out,
  output logic [arfcs_pkg::SEL_W-1:0] pos_select_out,
  output logic [arfcs_pkg::SEL_W-1:0] neg_select_out
);
  import arfcs_pkg::*;

  // Register state
  logic enable_reg;
  logic left_adjust_reg;
  logic diff_reg;
  logic [2:0] accumulation_count_reg;
  logic [3:0] presc_reg;
  logic [CNT_W-1:0] init_delay_reg;
  logic [CNT_W-1:0] sample_length_reg;
  logic [SEL_W-1:0] positive_input_select_reg;
  logic [SEL_W-1:0] negative_input_select_reg;
  logic start_conversion_cmd_reg;
  logic result_ready_flag_reg;
  // Sequencer state
  arfcs_state_e state_reg;
  logic [CNT_W-1:0] phase_cnt_reg;
  logic [7:0] samples_left_reg;
  logic [SUM_W-1:0] sum_reg;
  logic [3:0] div_cnt_reg;
  logic done_delay_reg;
  logic [RES_W-1:0] result_word;
  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic wb_wr_byte0;
  logic [31:0] rd_data_next;
  // Sequencer helpers
  logic tick;
  logic phase_last;
  logic conv_done;
  logic select_lock;
  logic temp_selected;
  logic [SUM_W-1:0] sample_ext;

  //////////////////////////////////////////////////////////////////////////////
  // Temperature sensor decode of a positive selection code
  function automatic logic is_temp_sensor(input logic [SEL_W-1:0] sel, input logic diff);
    is_temp_sensor = (sel == SEL_TEMP_SENSOR) && !diff;
  endfunction : is_temp_sensor

  // Sample count of an accumulation code, one to 128
  function automatic logic [7:0] samples_of(input logic [2:0] code);
    samples_of = 8'h01 << code;
  endfunction : samples_of

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack drops the cycle after it rises
  assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wb_wr = wb_req && wb_we_in;
  assign wb_wr_byte0 = wb_wr && wb_sel_in[0];

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_req;
    end
  end

  // Read mux, unmapped offsets read as zero
  always_comb begin
    rd_data_next = 32'h0000_0000;
    case (wb_adr_in)
      ADDR_CTRL: begin
        rd_data_next[CTRL_ENABLE_BIT] = enable_reg;
        rd_data_next[CTRL_LEFT_ADJUST_BIT] = left_adjust_reg;
        rd_data_next[CTRL_DIFF_BIT] = diff_reg;
      end
      ADDR_ACCUM: rd_data_next[2:0] = accumulation_count_reg;
      ADDR_PRESC: rd_data_next[3:0] = presc_reg;
      ADDR_INIT_DELAY: rd_data_next[CNT_W-1:0] = init_delay_reg;
      ADDR_SAMPLE_LENGTH: rd_data_next[CNT_W-1:0] = sample_length_reg;
      ADDR_POS_SELECT: rd_data_next[SEL_W-1:0] = positive_input_select_reg;
      ADDR_NEG_SELECT: rd_data_next[SEL_W-1:0] = negative_input_select_reg;
      ADDR_COMMAND: rd_data_next[CMD_START_BIT] = start_conversion_cmd_reg;
      ADDR_STATUS: rd_data_next[STATUS_READY_BIT] = result_ready_flag_reg;
      ADDR_RESULT: rd_data_next[RES_W-1:0] = result_word;
      ADDR_ACTIVE_SELECT: begin
        rd_data_next[SEL_W-1:0] = pos_select_out;
        rd_data_next[ACTIVE_NEG_LSB +: SEL_W] = neg_select_out;
      end
      default: rd_data_next = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_req && !wb_we_in) begin
      wb_dat_out <= rd_data_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers, all fields in byte lane 0
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_reg <= 1'b0;
      left_adjust_reg <= 1'b0;
      diff_reg <= 1'b0;
      accumulation_count_reg <= 3'h0;
      presc_reg <= PRESC_RESET;
      init_delay_reg <= INIT_DELAY_RESET;
      sample_length_reg <= SAMPLE_LENGTH_RESET;
      positive_input_select_reg <= SEL_RESET;
      negative_input_select_reg <= SEL_RESET;
    end else if (wb_wr_byte0) begin
      case (wb_adr_in)
        ADDR_CTRL: begin
          enable_reg <= wb_dat_in[CTRL_ENABLE_BIT];
          left_adjust_reg <= wb_dat_in[CTRL_LEFT_ADJUST_BIT];
          diff_reg <= wb_dat_in[CTRL_DIFF_BIT];
        end
        ADDR_ACCUM: accumulation_count_reg <= wb_dat_in[2:0];
        ADDR_PRESC: presc_reg <= wb_dat_in[3:0];
        ADDR_INIT_DELAY: init_delay_reg <= wb_dat_in[CNT_W-1:0];
        ADDR_SAMPLE_LENGTH: sample_length_reg <= wb_dat_in[CNT_W-1:0];
        ADDR_POS_SELECT: positive_input_select_reg <= wb_dat_in[SEL_W-1:0];
        ADDR_NEG_SELECT: negative_input_select_reg <= wb_dat_in[SEL_W-1:0];
        default: ;
      endcase
    end
  end

  // Start command: a software set wins over the completion clear
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      start_conversion_cmd_reg <= 1'b0;
    end else if (wb_wr_byte0 && wb_adr_in == ADDR_COMMAND && wb_dat_in[CMD_START_BIT]) begin
      start_conversion_cmd_reg <= 1'b1;
    end else if (conv_done || !enable_reg) begin
      start_conversion_cmd_reg <= 1'b0;
    end
  end

  // Result ready: set one cycle after the result loads, write 1 clears
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      result_ready_flag_reg <= 1'b0;
    end else if (done_delay_reg) begin
      result_ready_flag_reg <= 1'b1;
    end else if (wb_wr_byte0 && wb_adr_in == ADDR_STATUS && wb_dat_in[STATUS_READY_BIT]) begin
      result_ready_flag_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Converter clock: one-cycle enable every presc+1 reference cycles
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_cnt_reg <= 4'h0;
    end else if (div_cnt_reg >= presc_reg) begin
      div_cnt_reg <= 4'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end

  assign tick = (div_cnt_reg >= presc_reg);
  assign adc_clk_en_out = tick;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: INIT (init delay), then SAMPLE/CONVERT once per accumulated sample
  assign phase_last = (phase_cnt_reg == 8'h00);
  assign conv_done = (state_reg == ST_CONVERT) && phase_last && tick && (samples_left_reg == 8'h01);
  // Lock from start until the last converter cycle of the final conversion
  assign select_lock = (state_reg != ST_IDLE) &&
    !((state_reg == ST_CONVERT) && phase_last && (samples_left_reg == 8'h01));

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      phase_cnt_reg <= 8'h00;
      samples_left_reg <= 8'h00;
    end else if (!enable_reg) begin
      state_reg <= ST_IDLE;
    end else if (tick) begin
      case (state_reg)
        ST_IDLE: begin
          if (start_conversion_cmd_reg) begin
            state_reg <= ST_INIT;
            phase_cnt_reg <= init_delay_reg;
            samples_left_reg <= samples_of(accumulation_count_reg);
          end
        end
        ST_INIT: begin
          if (phase_last) begin
            state_reg <= ST_SAMPLE;
            phase_cnt_reg <= sample_length_reg;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end
        end
        ST_SAMPLE: begin
          if (phase_last) begin
            state_reg <= ST_CONVERT;
            phase_cnt_reg <= CONV_TICKS - 8'h01;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end
        end
        ST_CONVERT: begin
          if (!phase_last) begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end else if (samples_left_reg == 8'h01) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_SAMPLE;
            phase_cnt_reg <= sample_length_reg;
            samples_left_reg <= samples_left_reg - 8'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator: signed for differential, unsigned for single-ended
  assign sample_ext = diff_reg ? {{(SUM_W-CONV_W){adc_data_in[CONV_W-1]}}, adc_data_in}
                               : {{(SUM_W-CONV_W){1'b0}}, adc_data_in};

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sum_reg <= 19'h00000;
    end else if (tick && state_reg == ST_IDLE) begin
      sum_reg <= 19'h00000;
    end else if (tick && state_reg == ST_CONVERT && phase_last) begin
      sum_reg <= sum_reg + sample_ext;
    end
  end

  // Completion delay so the flag rises one cycle after the new result
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_delay_reg <= 1'b0;
    end else begin
      done_delay_reg <= conv_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Converter side outputs
  assign temp_selected = is_temp_sensor(pos_select_out, diff_reg);
  assign adc_sample_out = (state_reg == ST_SAMPLE);
  assign adc_convert_out = (state_reg == ST_CONVERT);
  assign diff_mode_out = diff_reg;
  assign temp_sensor_en_out = temp_selected;

  // Shadowed channel selection
  arfcs_input_select u_input_select (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .lock_in(select_lock),
    .pos_written_in(positive_input_select_reg),
    .neg_written_in(negative_input_select_reg),
    .pos_active_out(pos_select_out),
    .neg_active_out(neg_select_out)
  );

  // Result packing; the temperature sensor always reads right adjusted
  arfcs_result_format u_result_format (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .load_in(conv_done),
    .sum_in(sum_reg + sample_ext),
    .count_in(accumulation_count_reg),
    .left_in(left_adjust_reg && !temp_selected),
    .diff_in(diff_reg),
    .result_out(result_word)
  );

endmodule : arfcs_top

`default_nettype wire

//--- tb/arfcs_top_checker.sv
/* Checker for arfcs_top: bus handshake, sequencer phases and selection lock.
   Assumes it is bound to arfcs_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module arfcs_top_checker (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic adc_clk_en_out,
  input wire logic adc_sample_out,
  input wire logic adc_convert_out,
  input wire logic diff_mode_out,
  input wire logic temp_sensor_en_out,
  input wire logic [arfcs_pkg::SEL_W-1:0] pos_select_out
);
  import arfcs_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic [7:0] conv_ticks_reg;
  ////////////////////////////////////////////////////////////////
  // Counts converter ticks spent in the convert phase
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) conv_ticks_reg <= 8'h00;
    else if (!adc_convert_out) conv_ticks_reg <= 8'h00;
    else if (adc_clk_en_out) conv_ticks_reg <= conv_ticks_reg + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  a_ack_follows_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not acknowledged next cycle");
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("acknowledge longer than one cycle");
  a_upper_read_zero: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_tick_single: assert property (adc_clk_en_out |=> !adc_clk_en_out)
    else $error("converter tick wider than one cycle");
  a_sample_on_tick: assert property ($rose(adc_sample_out) |-> $past(adc_clk_en_out))
    else $error("sampling began off a converter tick");
  a_convert_after_sample: assert property ($rose(adc_convert_out) |-> $past(adc_sample_out) && $past(adc_clk_en_out))
    else $error("convert phase not entered from sampling on a tick");
  a_convert_length: assert property ($fell(adc_convert_out) |-> conv_ticks_reg == CONV_TICKS)
    else $error("convert phase length wrong");
  a_lock_sampling: assert property (adc_sample_out && $past(adc_sample_out) |-> $stable(pos_select_out))
    else $error("active selection moved while sampling");
  a_temp_decode: assert property ($stable(pos_select_out) && $stable(diff_mode_out)
    |-> temp_sensor_en_out == (pos_select_out == SEL_TEMP_SENSOR && !diff_mode_out))
    else $error("temperature sensor enable wrong");
  // Main scenarios reached
  c_conv_end: cover property ($fell(adc_convert_out));
  c_diff_sample: cover property ($rose(adc_sample_out) && diff_mode_out);
  c_temp_sample: cover property (temp_sensor_en_out && adc_sample_out);
endmodule : arfcs_top_checker

bind arfcs_top arfcs_top_checker u_checker (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .adc_clk_en_out(adc_clk_en_out),
  .adc_sample_out(adc_sample_out), .adc_convert_out(adc_convert_out), .diff_mode_out(diff_mode_out),
  .temp_sensor_en_out(temp_sensor_en_out), .pos_select_out(pos_select_out));
`default_nettype wire

//--- tb/test_arfcs_top.sv
/* Self-checking bench for arfcs_top: registers, result packing, accumulation
   and selection lock. Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_arfcs_top;
  import arfcs_pkg::*;
  logic ref_clk_in, reset_in, cyc, stb, we, ack, clk_en, sample, convert, diff_mode, temp_en;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [CONV_W-1:0] adc_data;
  logic [SEL_W-1:0] pos_sel, neg_sel;
  int failures, n_compared;

  arfcs_top u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .adc_data_in(adc_data),
    .adc_clk_en_out(clk_en), .adc_sample_out(sample), .adc_convert_out(convert), .diff_mode_out(diff_mode),
    .temp_sensor_en_out(temp_en), .pos_select_out(pos_sel), .neg_select_out(neg_sel));

  // Clock at 100 MHz
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  ////////////////////////////////////////////////////////////////
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One classic cycle; the answer lands in q
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      failures++;
      give_verdict();
    end
  endtask : wb_cycle

  task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0000_0000);
    check(name, exp, q);
  endtask : rd_check

  // Waits for the sample or convert phase to reach a level
  task automatic wait_phase(input logic conv, input logic lvl);
    int n;
    n = 0;
    while ((conv ? convert : sample) !== lvl && n < 400) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 400) begin
      failures++;
      give_verdict();
    end
  endtask : wait_phase

  task automatic start_conv(input logic [11:0] v);
    adc_data <= v;
    wb_cycle(1'b1, ADDR_COMMAND, 32'h0000_0001);
  endtask : start_conv

  // Polls ready, checks the result, the cleared command and the flag clear
  task automatic finish_conv(input logic [15:0] exp);
    int n;
    n = 0;
    q = 32'h0000_0000;
    while (q[0] !== 1'b1 && n < 3000) begin
      wb_cycle(1'b0, ADDR_STATUS, 32'h0000_0000);
      n++;
    end
    check("ready", 32'h0000_0001, q);
    rd_check("command", ADDR_COMMAND, 32'h0000_0000);
    rd_check("result", ADDR_RESULT, {16'h0000, exp});
    wb_cycle(1'b1, ADDR_STATUS, 32'h0000_0001);
    rd_check("ready cleared", ADDR_STATUS, 32'h0000_0000);
  endtask : finish_conv

  function automatic logic [15:0] expect_res(input logic [11:0] v, input int c, input logic left, input logic diff);
    logic signed [31:0] s;
    if (diff) s = 32'(signed'(v));
    else s = 32'(v);
    s = s * (1 << c);
    if (c > 4) s = s >>> (c - 4);
    else if (left) s = s << (4 - c);
    return s[15:0];
  endfunction : expect_res

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_in = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    adc_data = 12'h000;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd_check("prescaler", ADDR_PRESC, 32'h0000_0001);
    rd_check("init delay", ADDR_INIT_DELAY, 32'h0000_0000);
    wb_cycle(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd_check("unmapped", 8'h3C, 32'h0000_0000);
    $display("test registers done");
    // Tracking while idle, lock during the conversion, release at its end
    wb_cycle(1'b1, ADDR_POS_SELECT, 32'h0000_0011);
    wb_cycle(1'b1, ADDR_NEG_SELECT, 32'h0000_0033);
    rd_check("active select", ADDR_ACTIVE_SELECT, 32'h0000_3311);
    wb_cycle(1'b1, ADDR_CTRL, 32'h0000_0005);
    check("diff mode", 32'h1, 32'(diff_mode));
    start_conv(12'h123);
    wait_phase(1'b0, 1'b1);
    wb_cycle(1'b1, ADDR_POS_SELECT, 32'h0000_0022);
    wb_cycle(1'b1, ADDR_NEG_SELECT, 32'h0000_0044);
    wait_phase(1'b1, 1'b1);
    check("locked neg", 32'h33, 32'(neg_sel));
    rd_check("locked select", ADDR_ACTIVE_SELECT, 32'h0000_3311);
    wait_phase(1'b1, 1'b0);
    check("released pos", 32'h22, 32'(pos_sel));
    check("released neg", 32'h44, 32'(neg_sel));
    finish_conv(16'h0123);
    $display("test selection lock done");
    // Single-ended left adjust, then the temperature sensor forcing right adjust
    wb_cycle(1'b1, ADDR_CTRL, 32'h0000_0003);
    check("single mode", 32'h0, 32'(diff_mode));
    start_conv(12'hABC);
    finish_conv(16'hABC0);
    wb_cycle(1'b1, ADDR_POS_SELECT, {25'h0, SEL_TEMP_SENSOR});
    // Converter clock at 6.25 MHz: 158 init ticks cover 25 us, 177 sample ticks cover 28 us
    wb_cycle(1'b1, ADDR_PRESC, 32'h0000_000F);
    wb_cycle(1'b1, ADDR_INIT_DELAY, 32'h0000_009D);
    wb_cycle(1'b1, ADDR_SAMPLE_LENGTH, 32'h0000_00B0);
    rd_check("sample length", ADDR_SAMPLE_LENGTH, 32'h0000_00B0);
    repeat (2) @(posedge ref_clk_in);
    check("temp enable", 32'h1, 32'(temp_en));
    start_conv(12'hABC);
    finish_conv(16'h0ABC);
    // Back to the fast converter clock and short phases for the long sums
    wb_cycle(1'b1, ADDR_PRESC, 32'h0000_0001);
    wb_cycle(1'b1, ADDR_INIT_DELAY, 32'h0000_0000);
    wb_cycle(1'b1, ADDR_SAMPLE_LENGTH, 32'h0000_0000);
    $display("test single-ended done");
    // Differential packing for every accumulation count, both adjustments
    for (int k = 0; k < 4; k++) begin
      wb_cycle(1'b1, ADDR_CTRL, {29'h0, 1'b1, k[0], 1'b1});
      for (int c = 0; c < 8; c++) begin
        wb_cycle(1'b1, ADDR_ACCUM, 32'(c));
        start_conv(k[1] ? 12'h7FF : 12'h801);
        finish_conv(expect_res(k[1] ? 12'h7FF : 12'h801, c, k[0], 1'b1));
      end
    end
    $display("test accumulation done");
    give_verdict();
  end
endmodule : test_arfcs_top
`default_nettype wire
